// ===== logic/spi_port.sv
// How it works
// - transmit and receive shift registers move one bit per serial clock period, transmit on the drive edge, receive on the sample edge.
// - as master, drive the clock, the slave selects and MOSI; sample MISO.
// - as slave, shift MOSI in and drive the transmit register onto MISO.
// - buffered transmit words load the shifter; finished words land in receive buffer.
// - master drives up to four select outputs wired to slave selects.
// - serial clock toggles only during a word, one active edge per bit.
// - master clock rate comes from a 15-bit divisor, at most a quarter core rate.
// - slave ignores divisor and treats the clock pin as input; master drives it.
// - slave ignores serial clock while its select input is high.
// - data changes on active edge, sampled on opposite; polarity bit 11, phase bit 10.
// - at least two clock periods between last edge of a word and next first.
// - phase 0: hardware drives enabled selects; phase 1: software select values.
// - select input is active low, input only, driven by the remote master.
// - as master, a low select input is a mode fault from another master.
// - MOSI is output as master, input as slave.
// - MISO is input as master, output as slave.
// - always full duplex, except broadcast slaves that receive without driving MISO.
// - disabled port does no transfers; flag pins go general purpose; select resets slave.
// - open drain: data output floats for one, drives low for zero.
// - empty transmit buffer sends zeros or repeats the last word.
// - full receive buffer is overwritten with get-more, else new word is dropped.
module spi_port #(
    parameter int WORD_W     = spi_pkg::WORD_W_DEF,
    parameter int FIFO_DEPTH = spi_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // configuration
    input  wire logic                       port_enable,
    input  wire logic                       master_mode,
    input  wire logic                       multimaster_enable,
    input  wire logic [spi_pkg::CTRL_W-1:0] port_control_reg,
    input  wire logic                       open_drain_enable,
    input  wire logic                       send_zeros,
    input  wire logic                       get_more,
    input  wire logic                       miso_drive_enable,
    input  wire logic [spi_pkg::BAUD_W-1:0] baud_divisor,
    input  wire logic [spi_pkg::SEL_N-1:0]  select_output_enable,
    input  wire logic [spi_pkg::SEL_N-1:0]  select_output_value,
    input  wire logic [spi_pkg::SEL_N-1:0]  flag_pins_gpio,
    // transmit buffer fill side
    input  wire logic                       tx_valid,
    input  wire logic [WORD_W-1:0]          tx_data,
    output logic                            tx_ready,
    input  wire logic                       start_xfer,
    // receive buffer
    output logic                            rx_valid,
    output logic [WORD_W-1:0]               rx_data,
    input  wire logic                       rx_ready,
    // status
    output logic                            busy,
    output logic                            tx_empty,
    output logic                            mode_fault_error,
    output logic                            mode_fault_event,
    input  wire logic                       mode_fault_clear,
    // serial pins
    input  wire logic                       serial_clock_pin_in,
    output logic                            serial_clock_pin_out,
    output logic                            serial_clock_pin_oe,
    input  wire logic                       mosi_in,
    output logic                            mosi_out,
    output logic                            mosi_oe,
    input  wire logic                       miso_in,
    output logic                            miso_out,
    output logic                            miso_oe,
    input  wire logic                       device_select_in_n,
    output logic [spi_pkg::SEL_N-1:0]       select_outputs
);
    localparam int BW = $clog2(WORD_W) + 1;
    localparam int EW = $clog2(2 * WORD_W) + 1;
    localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_W - 1);
    localparam logic [BW-1:0] LAST_BIT  = BW'(WORD_W - 1);

    // never below the floor, so the clock stays at or under a quarter core rate
    function automatic logic [spi_pkg::BAUD_W-1:0] half_len(input logic [spi_pkg::BAUD_W-1:0] d);
        half_len = (d < spi_pkg::MIN_HALF) ? spi_pkg::MIN_HALF : d;
    endfunction : half_len

    // =====================================================
    // pin synchronisers: sclk, mosi, miso, select
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       sclk_d_r;
    logic       sel_d_r;
    logic       sclk_s;
    logic       mosi_s;
    logic       miso_s;
    logic       sel_s_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r  <= 4'hF;
            sync2_r  <= 4'hF;
            sclk_d_r <= 1'b1;
            sel_d_r  <= 1'b1;
        end else begin
            sync1_r  <= {device_select_in_n, miso_in, mosi_in, serial_clock_pin_in};
            sync2_r  <= sync1_r;
            sclk_d_r <= sync2_r[0];
            sel_d_r  <= sync2_r[3];
        end
    end
    assign sclk_s  = sync2_r[0];
    assign mosi_s  = sync2_r[1];
    assign miso_s  = sync2_r[2];
    assign sel_s_n = sync2_r[3];

    // =====================================================
    // mode decode
    logic cpol;
    logic cpha;
    logic fault_now;
    logic mode_fault_r;
    logic run;
    logic slave_sel;

    assign cpol      = port_control_reg[spi_pkg::CPOL_POS];
    assign cpha      = port_control_reg[spi_pkg::CPHA_POS];
    assign fault_now = port_enable && master_mode && multimaster_enable && !sel_s_n;
    assign run       = port_enable && master_mode && !mode_fault_r;
    // slave logic sees the clock only while selected and enabled
    assign slave_sel = port_enable && !master_mode && !sel_s_n;

    // =====================================================
    // transmit buffer
    fifo_if #(.W(WORD_W)) txq ();

    word_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .fq    (txq.buffer)
    );

    assign txq.fill_valid = tx_valid;
    assign txq.fill_data  = tx_data;
    assign tx_ready       = txq.fill_ready;
    assign tx_empty       = !txq.drain_valid;

    // =====================================================
    // master sequencer and clock generator
    spi_pkg::state_t             state_r;
    spi_pkg::state_t             state_nxt;
    logic [spi_pkg::BAUD_W-1:0]  half_cnt_r;
    logic [2:0]                  halves_r;
    logic [EW-1:0]               edge_idx_r;
    logic                        sclk_r;
    logic                        tick;
    logic                        go;

    assign tick = (state_r != spi_pkg::ST_IDLE) && (half_cnt_r == '0);
    assign go   = run && (txq.drain_valid || start_xfer);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            spi_pkg::ST_IDLE:  if (go) state_nxt = spi_pkg::ST_LEAD;
            spi_pkg::ST_LEAD:  if (tick && halves_r == 3'(spi_pkg::LEAD_HALVES - 1)) state_nxt = spi_pkg::ST_SHIFT;
            spi_pkg::ST_SHIFT: if (tick && edge_idx_r == LAST_EDGE) state_nxt = spi_pkg::ST_LAG;
            spi_pkg::ST_LAG:   if (tick && halves_r == 3'(spi_pkg::LAG_HALVES - 1)) state_nxt = spi_pkg::ST_GAP;
            spi_pkg::ST_GAP:   if (tick && halves_r == 3'(spi_pkg::GAP_HALVES - 1)) state_nxt = spi_pkg::ST_IDLE;
            default:           state_nxt = spi_pkg::ST_IDLE;
        endcase
        if (!run) begin
            state_nxt = spi_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= spi_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_cnt_r <= '0;
            halves_r   <= '0;
        end else begin
            if (state_r == spi_pkg::ST_IDLE || tick) begin
                half_cnt_r <= half_len(baud_divisor) - 1'b1;
            end else begin
                half_cnt_r <= half_cnt_r - 1'b1;
            end
            if (state_nxt != state_r) begin
                halves_r <= '0;
            end else if (tick) begin
                halves_r <= halves_r + 1'b1;
            end
        end
    end

    // gated clock: toggles only in the shift state, 2*WORD_W edges a word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_r     <= 1'b0;
            edge_idx_r <= '0;
        end else if (state_r == spi_pkg::ST_SHIFT) begin
            if (tick) begin
                sclk_r     <= !sclk_r;
                edge_idx_r <= edge_idx_r + 1'b1;
            end
        end else begin
            sclk_r     <= cpol;
            edge_idx_r <= '0;
        end
    end

    // =====================================================
    // edge events shared by master and slave
    logic m_lead;
    logic m_trail;
    logic s_lead;
    logic s_trail;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic drive_ev;
    logic load_ev;
    logic din;
    logic word_done;
    logic [BW-1:0] bit_cnt_r;
    logic [1:0]    m_samp_r;

    assign m_lead    = (state_r == spi_pkg::ST_SHIFT) && tick && !edge_idx_r[0];
    assign m_trail   = (state_r == spi_pkg::ST_SHIFT) && tick && edge_idx_r[0];
    assign s_lead    = slave_sel && (sclk_s != cpol) && (sclk_d_r == cpol);
    assign s_trail   = slave_sel && (sclk_s == cpol) && (sclk_d_r != cpol);
    assign lead_ev   = master_mode ? m_lead : s_lead;
    assign trail_ev  = master_mode ? m_trail : s_trail;
    // master samples late by the synchroniser depth, so a quarter-rate bit is still the right one
    assign sample_ev = master_mode ? m_samp_r[1] : (cpha ? s_trail : s_lead);
    assign drive_ev  = cpha ? lead_ev : trail_ev;
    assign din       = master_mode ? miso_s : mosi_s;
    assign word_done = sample_ev && (bit_cnt_r == LAST_BIT);
    // slave loads on select fall; phase 1 words may follow without a select toggle
    assign load_ev   = master_mode ? (state_r == spi_pkg::ST_IDLE && go)
                                   : (slave_sel && (sel_d_r || (word_done && cpha)));
    assign txq.drain_ready = load_ev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m_samp_r <= 2'h0;
        end else begin
            m_samp_r <= {m_samp_r[0], (cpha ? m_trail : m_lead)};
        end
    end

    // =====================================================
    // shift registers
    logic [WORD_W-1:0] tx_sr_r;
    logic [WORD_W-1:0] rx_sr_r;
    logic [WORD_W-1:0] last_word_r;
    logic [WORD_W-1:0] next_word;
    logic [WORD_W-1:0] rx_word;
    logic              out_bit_r;

    assign next_word = txq.drain_valid ? txq.drain_data
                     : (send_zeros ? '0 : last_word_r);
    assign rx_word   = {rx_sr_r[WORD_W-2:0], din};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_sr_r     <= '0;
            last_word_r <= '0;
            out_bit_r   <= 1'b0;
        end else if (load_ev) begin
            last_word_r <= next_word;
            if (cpha) begin
                tx_sr_r <= next_word;
            end else begin
                // phase 0 puts the first bit out before the first edge
                out_bit_r <= next_word[WORD_W-1];
                tx_sr_r   <= {next_word[WORD_W-2:0], 1'b0};
            end
        end else if (drive_ev) begin
            out_bit_r <= tx_sr_r[WORD_W-1];
            tx_sr_r   <= {tx_sr_r[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_sr_r   <= '0;
            bit_cnt_r <= '0;
        end else begin
            if (sample_ev) begin
                rx_sr_r <= rx_word;
            end
            if ((!master_mode && !slave_sel) || (master_mode && load_ev) || word_done) begin
                bit_cnt_r <= '0;
            end else if (sample_ev) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // =====================================================
    // receive buffer, with get-more a new word wins over a read in the same cycle
    logic              rx_full_r;
    logic [WORD_W-1:0] rx_data_r;
    logic              rx_take;

    assign rx_take = word_done && (!rx_full_r || get_more);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_full_r <= 1'b0;
            rx_data_r <= '0;
        end else begin
            if (rx_take) begin
                rx_full_r <= 1'b1;
                rx_data_r <= rx_word;
            end else if (rx_ready && rx_full_r) begin
                rx_full_r <= 1'b0;
            end
        end
    end
    assign rx_valid = rx_full_r;
    assign rx_data  = rx_data_r;
    assign busy     = (state_r != spi_pkg::ST_IDLE) || (slave_sel && bit_cnt_r != '0);

    // =====================================================
    // mode fault
    logic fault_ev_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_fault_r <= 1'b0;
            fault_ev_r   <= 1'b0;
        end else begin
            fault_ev_r <= fault_now && !mode_fault_r;
            if (fault_now) begin
                mode_fault_r <= 1'b1;
            end else if (mode_fault_clear) begin
                mode_fault_r <= 1'b0;
            end
        end
    end
    assign mode_fault_error = mode_fault_r;
    assign mode_fault_event = fault_ev_r;

    // =====================================================
    // select outputs and pin drivers
    logic [spi_pkg::SEL_N-1:0] sel_r;
    logic                      framing;

    assign framing = (state_r == spi_pkg::ST_LEAD) || (state_r == spi_pkg::ST_SHIFT)
                  || (state_r == spi_pkg::ST_LAG);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_r <= spi_pkg::SEL_IDLE;
        end else if (!port_enable || !master_mode) begin
            sel_r <= flag_pins_gpio;
        end else if (cpha) begin
            sel_r <= select_output_value;
        end else begin
            sel_r <= ~(select_output_enable & {spi_pkg::SEL_N{framing}});
        end
    end
    assign select_outputs = sel_r;

    // open drain: data pins drive only zeros, a pull-up supplies the ones
    assign serial_clock_pin_out = sclk_r;
    assign serial_clock_pin_oe  = run;
    assign mosi_out = open_drain_enable ? 1'b0 : out_bit_r;
    assign mosi_oe  = run && (!open_drain_enable || !out_bit_r);
    assign miso_out = open_drain_enable ? 1'b0 : out_bit_r;
    assign miso_oe  = slave_sel && miso_drive_enable
                   && (!open_drain_enable || !out_bit_r);

    // =====================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence gap_entry;
        state_r == spi_pkg::ST_LAG ##1 state_r == spi_pkg::ST_GAP;
    endsequence

    a_gap_two_periods: assert property (disable iff (!rst_n || !run)
        gap_entry |=> (state_r == spi_pkg::ST_GAP)[*7])
        else $error("word gap shorter than two serial clock periods");
    a_baud_floor: assert property (
        (state_r == spi_pkg::ST_SHIFT) && (sclk_r != $past(sclk_r)) |=> sclk_r == $past(sclk_r))
        else $error("serial clock faster than a quarter core rate");
    a_fault_detect: assert property (fault_now |=> mode_fault_r && $rose(mode_fault_event)
        || mode_fault_r && $past(mode_fault_r))
        else $error("mode fault not flagged");
    a_fault_sticky: assert property (mode_fault_r && !mode_fault_clear |=> mode_fault_r)
        else $error("mode fault dropped without clear");
    a_slave_clock_in: assert property (!master_mode |-> !serial_clock_pin_oe && !mosi_oe)
        else $error("slave drives master pins");
    a_miso_float: assert property (sel_s_n || !port_enable |-> !miso_oe)
        else $error("miso driven while deselected");
    a_open_drain: assert property (open_drain_enable && (mosi_oe || miso_oe)
        |-> !out_bit_r && !mosi_out && !miso_out)
        else $error("open drain drove a one");
    a_rx_discard: assert property (word_done && rx_full_r && !get_more
        |=> rx_full_r && rx_data_r == $past(rx_data_r))
        else $error("full receive buffer overwritten");
    a_rx_move: assert property (word_done && !rx_full_r |=> rx_full_r && rx_data_r == $past(rx_word))
        else $error("received word not moved to buffer");
    a_disabled_idle: assert property (!port_enable |=> state_r == spi_pkg::ST_IDLE ##1 !busy)
        else $error("transfer while port disabled");
endmodule : spi_port

// ===== logic/spi_pkg.sv
package spi_pkg;
    // =====================================================
    // widths and depths
    localparam int WORD_W_DEF     = 8;
    localparam int FIFO_DEPTH_DEF = 32;
    localparam int BAUD_W         = 15;
    localparam int SEL_N          = 4;
    // =====================================================
    // control word field positions
    localparam int CTRL_W         = 16;
    localparam int CPOL_POS       = 11;
    localparam int CPHA_POS       = 10;
    // =====================================================
    // timing: half-period floor in core clock cycles, the rest in half periods of the serial clock
    localparam logic [BAUD_W-1:0] MIN_HALF = 15'h0002;
    localparam int LEAD_HALVES    = 1;
    localparam int LAG_HALVES     = 1;
    localparam int GAP_HALVES     = 4;
    // =====================================================
    // reset values
    localparam logic [SEL_N-1:0] SEL_IDLE = 4'hF;
    // =====================================================
    // master sequencer
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_SHIFT = 3'h3,
        ST_LAG   = 3'h2,
        ST_GAP   = 3'h6
    } state_t;
endpackage : spi_pkg

// ===== logic/fifo_if.sv
interface fifo_if #(
    parameter int W = 8
);
    logic         fill_valid;
    logic         fill_ready;
    logic [W-1:0] fill_data;
    logic         drain_valid;
    logic         drain_ready;
    logic [W-1:0] drain_data;

    modport buffer (
        input  fill_valid, fill_data, drain_ready,
        output fill_ready, drain_valid, drain_data
    );
    modport user (
        output fill_valid, fill_data, drain_ready,
        input  fill_ready, drain_valid, drain_data
    );
endinterface : fifo_if

// ===== logic/word_fifo.sv
module word_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // both sides
    fifo_if.buffer    fq
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic         full;
    logic         empty;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign fq.fill_ready  = !full;
    assign fq.drain_valid = !empty;
    assign fq.drain_data  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (fq.fill_valid && !full) begin
            mem[wr_ptr_r[AW-1:0]] <= fq.fill_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (fq.fill_valid && !full) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (fq.drain_ready && !empty) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule : word_fifo

// ===== tb/spi_slave_model.sv
module spi_slave_model (
    // serial side
    input  wire logic       sclk,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    output logic            miso,
    // bench side
    input  wire logic [7:0] reply,
    output logic [7:0]      got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_r;
    // ==========================================
    // mode 0 slave: change on falling, sample on rising
    always @(negedge sel_n) sh_r = reply;
    always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
    always @(negedge sclk) if (!sel_n) sh_r = {sh_r[6:0], 1'b0};
    // deselected: inverse level, so a stale bit never reads as data
    assign miso = sel_n ? ~sh_r[7] : sh_r[7];
endmodule : spi_slave_model

// ===== tb/test_spi_port.sv
module test_spi_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, port_enable, master_mode, multimaster_enable, send_zeros, get_more, open_drain_enable;
    logic        tx_valid, start_xfer, rx_ready, mode_fault_clear, sclk, mosi, device_select_in_n;
    logic [7:0]  tx_data, reply, lfsr_r, w, m, a;
    logic [3:0]  flag_pins_gpio;
    logic [14:0] baud_divisor;
    wire         tx_ready, rx_valid, busy, tx_empty, mode_fault_error, mode_fault_event, miso_w;
    wire         serial_clock_pin_out, serial_clock_pin_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    wire [7:0]   rx_data, got;
    wire [3:0]   select_outputs;
    int          bad_count, tests_run, cyc, edges, ev_n;
    time         t_last, per;
    spi_port dut (.clk, .rst_n, .port_enable, .master_mode, .multimaster_enable, .port_control_reg(16'h0000),
        .open_drain_enable, .send_zeros, .get_more, .miso_drive_enable(1'b1), .baud_divisor,
        .select_output_enable(4'h1), .select_output_value(4'hF), .flag_pins_gpio, .tx_valid, .tx_data,
        .tx_ready, .start_xfer, .rx_valid, .rx_data, .rx_ready, .busy, .tx_empty, .mode_fault_error,
        .mode_fault_event, .mode_fault_clear, .serial_clock_pin_in(sclk), .serial_clock_pin_out,
        .serial_clock_pin_oe, .mosi_in(mosi), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
        .device_select_in_n, .select_outputs);
    spi_slave_model partner (.sclk(serial_clock_pin_out), .sel_n(select_outputs[0]), .mosi(mosi_out),
        .miso(miso_w), .reply, .got);
    // ==========================================
    // helpers
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction : rnd
    // rising-edge spacing of the master clock: two halves, divisor floored at two
    function automatic logic [15:0] period_ns(input logic [14:0] d);
        return 16'(((d < 15'h0002) ? 15'h0002 : d) * 40);
    endfunction : period_ns
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask : check
    task automatic idle();
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
    endtask : idle
    // bounded waits only: a stuck sequencer must not hang the loop
    task automatic xfer(input logic [7:0] r, input logic f);
        reply = r;
        idle();
        edges = 0;
        tx_valid = f;
        start_xfer = !f;
        @(negedge clk);
        {tx_valid, start_xfer} = 2'b00;
        @(negedge clk);
        idle();
    endtask : xfer
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge serial_clock_pin_out) begin
        edges++;
        per = $time - t_last;
        t_last = $time;
    end
    always @(posedge clk) begin
        ev_n += (mode_fault_event === 1'b1);
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, tx_valid, start_xfer, rx_ready, mode_fault_clear, multimaster_enable} = '0;
        {send_zeros, get_more, open_drain_enable, sclk, mosi, tx_data, reply, ev_n, cyc, bad_count, tests_run} = '0;
        {port_enable, master_mode, device_select_in_n, flag_pins_gpio, baud_divisor} = {3'b111, 4'h5, 15'h0};
        lfsr_r = 8'h0C;
        repeat (3) @(negedge clk);
        rst_n = 1;
        check(select_outputs, 4'hF);
        for (int i = 0; i < 4; i++) begin
            baud_divisor = (i == 0) ? 15'h0 : 15'(i + 1);
            w = rnd();
            tx_data = w;
            xfer(rnd(), 1'b1);
            check(got, tx_data);
            check(rx_data, reply);
            check(16'(edges), 16'h0008);
            check(per[15:0], period_ns(baud_divisor));
            check({serial_clock_pin_oe, mosi_oe, miso_oe}, 3'b110);
            rx_ready = 1;
            @(negedge clk);
            rx_ready = 0;
        end
        $display("master words finished");
        xfer(rnd(), 1'b0);
        a = reply;
        check(got, w);
        send_zeros = 1;
        xfer(rnd(), 1'b0);
        check(got, 8'h00);
        xfer(rnd(), 1'b0);
        check(rx_data, a);
        get_more = 1;
        xfer(rnd(), 1'b0);
        check(rx_data, reply);
        rx_ready = 1;
        @(negedge clk);
        rx_ready = 0;
        $display("empty and full buffer finished");
        multimaster_enable = 1;
        device_select_in_n = 0;
        repeat (6) @(negedge clk);
        check({mode_fault_error, serial_clock_pin_oe}, 2'b10);
        device_select_in_n = 1;
        repeat (6) @(negedge clk);
        check(mode_fault_error, 1'b1);
        mode_fault_clear = 1;
        repeat (2) @(negedge clk);
        mode_fault_clear = 0;
        check({mode_fault_error, 8'(ev_n)}, 9'h001);
        $display("mode fault finished");
        {multimaster_enable, master_mode} = 2'b00;
        w = rnd();
        reply = rnd();
        tx_data = w;
        tx_valid = 1;
        @(negedge clk);
        tx_valid = 0;
        check({tx_ready, tx_empty}, 2'b10);
        repeat (16) begin
            repeat (4) @(negedge clk);
            sclk = ~sclk;
        end
        check({rx_valid, miso_oe}, 2'b00);
        device_select_in_n = 0;
        repeat (5) @(negedge clk);
        check({miso_oe, tx_empty}, 2'b11);
        for (int b = 7; b >= 0; b--) begin
            mosi = reply[b];
            repeat (4) @(negedge clk);
            sclk = 1;
            m[b] = miso_out;
            repeat (4) @(negedge clk);
            sclk = 0;
        end
        repeat (6) @(negedge clk);
        open_drain_enable = 1;
        @(negedge clk);
        check({miso_out, miso_oe}, 2'b01);
        device_select_in_n = 1;
        check({rx_data, m}, {reply, w});
        $display("slave word finished");
        port_enable = 0;
        flag_pins_gpio = 4'(rnd());
        repeat (2) @(negedge clk);
        check(select_outputs, flag_pins_gpio);
        $display("disable finished");
        print_verdict();
    end
endmodule : test_spi_port
